// ==== dram_burst_order.sv ====
// column order of one beat within a read or write burst
`timescale 1ns/1ps
module dram_burst_order (
  input  wire logic [2:0] i_start,
  input  wire logic [2:0] i_beat,
  input  wire logic       i_interleave,
  input  wire logic       i_write,
  input  wire logic       i_chop,
  output logic      [2:0] o_col
);

  always_comb
  begin
    if (i_write)
    begin
      // low column bits are ignored, ca2 picks the nibble for chop
      o_col = i_chop ? {i_start[2], i_beat[1:0]} : i_beat;
    end
    else if (i_interleave)
    begin
      o_col = i_start ^ i_beat;
    end
    else
    begin
      o_col = {i_start[2] ^ i_beat[2], 2'(i_start[1:0] + i_beat[1:0])};
    end
  end

endmodule // dram_burst_order

// ==== dram_ctrl_model.sv ====
// controller-side model driving the memory reset, command and address pins
`timescale 1ns/1ps
module dram_ctrl_model #(
  parameter int TMOD = 12
) (
  input  wire logic        i_ck,
  output logic             o_reset_n,
  output logic             o_odt,
  output logic             o_cke,
  output logic             o_cs_n,
  output logic             o_ras_n,
  output logic             o_cas_n,
  output logic             o_we_n,
  output logic      [2:0]  o_ba,
  output logic      [14:0] o_addr
);
  initial
  begin
    o_reset_n = 1'b0;
    o_odt = 1'b0;
    o_cke = 1'b0;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hf;
    o_ba = 3'h0;
    o_addr = 15'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // deselect afterwards; stale bank and address lines flip so no old value lingers
  task automatic issue(input logic [2:0] rcw, input logic [2:0] ba, input logic [14:0] a);
    @(posedge i_ck);
    o_cs_n <= 1'b0;
    {o_ras_n, o_cas_n, o_we_n} <= rcw;
    o_ba <= ba;
    o_addr <= a;
    @(posedge i_ck);
    o_cs_n <= 1'b1;
    o_ba <= ~ba;
    o_addr <= ~a;
  endtask

  task automatic mem_reset();
    @(posedge i_ck);
    o_reset_n <= 1'b0;
    o_cke <= 1'b0;
    repeat (3) @(posedge i_ck);
    o_reset_n <= 1'b1;
    repeat (4) @(posedge i_ck);
    o_cke <= 1'b1;
    repeat (2) @(posedge i_ck);
  endtask

  // every field driven except test mode; mode zero keeps its zero-only bits and the test bit (a7) clear
  task automatic mrs(input logic [2:0] ba, input logic [14:0] a);
    // termination kept off around every mode write, whatever it is set to
    o_odt <= 1'b0;
    issue(3'b000, ba, (ba == 3'h0) ? (a & 15'h1f7f) : a);
    repeat (TMOD) @(posedge i_ck);
  endtask

  task automatic rw(input logic wr, input logic [14:0] a);
    issue(wr ? 3'b100 : 3'b101, 3'h0, a);
  endtask
endmodule // dram_ctrl_model

// ==== dram_mr0_pkg.sv ====
// types and field decoders for the mode register zero block
package dram_mr0_pkg;

  typedef enum logic [1:0] {
    BL_FIXED8 = 2'b00,
    BL_OTF    = 2'b01,
    BL_FIXED4 = 2'b10,
    BL_RSVD   = 2'b11
  } burst_mode_t;

  typedef enum logic [1:0] {
    LK_IDLE = 2'b00,
    LK_LAT  = 2'b01,
    LK_BEAT = 2'b10
  } link_state_t;

  typedef struct packed {
    logic [14:0] mr0;
    logic        loaded;
    logic        mr0_tog;
    logic        dll_bit;
    logic [7:0]  mod_cnt;
    link_state_t st;
    logic [3:0]  lat;
    logic [2:0]  beat;
    logic [2:0]  start;
    logic        wr;
    logic        chop;
    logic        ord;
    logic        vld;
    logic [2:0]  col;
    logic        oe;
    logic        wen;
  } link_st_t;

  typedef struct packed {
    logic [2:0]  tog_s;
    logic [2:0]  dll_s;
    logic [1:0]  rpin_s;
    logic [14:0] mr0;
    logic        loaded;
    logic        dll_evt;
  } core_st_t;

  // 0 marks a reserved code
  function automatic logic [3:0] cl_decode(input logic [2:0] a64, input logic a2);
    logic [3:0] v;
    v = 4'h0;
    case ({a2, a64})
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: v = {1'b0, a64} + 4'h4;
      4'h8: v = 4'hc;
      4'h9: v = 4'hd;
      4'ha: v = 4'he;
      default: v = 4'h0;
    endcase
    return v;
  endfunction

  function automatic logic [3:0] wr_decode(input logic [2:0] code);
    logic [3:0] v;
    v = 4'h0;
    case (code)
      3'h1: v = 4'h5;
      3'h2: v = 4'h6;
      3'h3: v = 4'h7;
      3'h4: v = 4'h8;
      3'h5: v = 4'ha;
      3'h6: v = 4'hc;
      3'h7: v = 4'he;
      default: v = 4'h0;
    endcase
    return v;
  endfunction

endpackage

// ==== dram_mr0_regs.svh ====
// constants for mode register zero, burst sequencing and link timing
`ifndef DRAM_MR0_REGS_SVH
`define DRAM_MR0_REGS_SVH

// mode register select on bank pins
`define MR0_SEL          3'h0
// field positions inside the 15-bit address word
`define MR0_BL_LSB       0
`define MR0_CL_LOW       2
`define MR0_ORDER        3
`define MR0_CL_LSB       4
`define MR0_TEST         7
`define MR0_DLL          8
`define MR0_WR_LSB       9
`define MR0_PD           12
`define MR0_ZERO_LSB     13
// column bit that carries burst chop with a read or write
`define BC_BIT           12
`define MR0_RESET_VAL    15'h0000

// timing counts in link clock cycles, and the index of the last burst beat
`define TMOD_CK          8'h0c
`define WRITE_LAT_CK     4'h5
`define TRP_CK           4'h9
`define TXP_CK           4'h3
`define TXPDLL_CK        4'ha
`define BURST_LAST       3'h7

`endif

// ==== dram_mr0_top.sv ====
// mode register zero, reset handling and burst sequencing of the memory
// Notes on behaviour
// - mode registers undefined until written after reset
// - mode writes and dll reset keep array
// - features settle within tMOD; only nop meanwhile
// - all four strobes low; bank code selects
// - a1:a0 choose fixed eight, otf, chop
// - otf mode: bc pin picks chop per command
// - a3 picks sequential or interleaved read order
// - cas latency codes map to five..fourteen
// - write recovery codes map to cycle counts
// - write recovery plus precharge forms tDAL
// - read order from start column bits
// - chop read: drivers off for last four
// - writes ignore ca1:ca0; chop uses ca2 nibble
// - dll reset bit clears itself
// - a12 selects slow or fast powerdown exit
`timescale 1ns/1ps
`include "dram_mr0_regs.svh"
module dram_mr0_top #(
  parameter logic [7:0] TMOD_CK   = `TMOD_CK,
  parameter logic [3:0] WRITE_LAT = `WRITE_LAT_CK,
  parameter logic [3:0] TRP_CK    = `TRP_CK,
  parameter logic [3:0] TXP_CK    = `TXP_CK,
  parameter logic [3:0] TXPDLL_CK = `TXPDLL_CK
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_resetn,
  input  wire logic                      i_ce,
  input  wire logic                      i_ck,
  input  wire logic                      i_dram_reset_n,
  input  wire logic                      i_cke,
  input  wire logic                      i_cs_n,
  input  wire logic                      i_ras_n,
  input  wire logic                      i_cas_n,
  input  wire logic                      i_we_n,
  input  wire logic [2:0]                i_ba,
  input  wire logic [14:0]               i_addr,
  output logic                           o_beat_valid,
  output logic      [2:0]                o_beat_col,
  output logic                           o_dq_oe,
  output logic                           o_wr_beat_en,
  output logic                           o_mrs_settling,
  output logic                           o_dll_reset_start,
  output logic                           o_mr0_loaded,
  output dram_mr0_pkg::burst_mode_t      o_burst_mode,
  output logic                           o_burst_interleaved,
  output logic      [3:0]                o_cas_latency,
  output logic      [3:0]                o_write_recovery,
  output logic      [4:0]                o_tdal_cycles,
  output logic                           o_factory_test,
  output logic                           o_pd_fast_exit,
  output logic      [3:0]                o_pd_exit_cycles,
  output logic                           o_dll_reset_seen,
  output logic                           o_mr0_reserved
);
  import dram_mr0_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // reset release: both resets assert at once and leave through two flops

  logic [1:0] crst_r;
  logic [1:0] lrst_r;
  logic       crst_n;
  logic       lrst_n;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      crst_r <= 2'h0;
    else
      crst_r <= {crst_r[0], 1'b1};
  end

  // the memory reset pin clears the link side without a clock
  always_ff @(posedge i_ck or negedge i_dram_reset_n)
  begin
    if (!i_dram_reset_n)
      lrst_r <= 2'h0;
    else
      lrst_r <= {lrst_r[0], 1'b1};
  end

  assign crst_n = crst_r[1];
  assign lrst_n = lrst_r[1];

  //////////////////////////////////////////////////////////////////////////////
  // link side: command decode, mode register zero, burst sequencer

  link_st_t    ls_r;
  link_st_t    ls_nxt;
  burst_mode_t lmode;
  logic        cmd_mrs;
  logic        cmd_rd;
  logic        cmd_wr;
  logic [2:0]  seq_beat;
  logic [2:0]  seq_col;
  logic [3:0]  link_cl;

  assign lmode    = burst_mode_t'(ls_r.mr0[`MR0_BL_LSB +: 2]);
  assign link_cl  = cl_decode(ls_r.mr0[`MR0_CL_LSB +: 3], ls_r.mr0[`MR0_CL_LOW]);
  // commands only count while cke is registered high
  assign cmd_mrs  = i_cke & ~i_cs_n & ~i_ras_n & ~i_cas_n & ~i_we_n;
  assign cmd_rd   = i_cke & ~i_cs_n & i_ras_n & ~i_cas_n & i_we_n;
  assign cmd_wr   = i_cke & ~i_cs_n & i_ras_n & ~i_cas_n & ~i_we_n;
  assign seq_beat = (ls_r.st == LK_BEAT) ? ls_r.beat : 3'h0;

  dram_burst_order u_order (
    .i_start      (ls_r.start),
    .i_beat       (seq_beat),
    .i_interleave (ls_r.ord),
    .i_write      (ls_r.wr),
    .i_chop       (ls_r.chop),
    .o_col        (seq_col)
  );

  always_comb
  begin
    ls_nxt         = ls_r;
    ls_nxt.dll_bit = 1'b0;
    ls_nxt.vld     = 1'b0;
    ls_nxt.oe      = 1'b0;
    ls_nxt.wen     = 1'b0;
    if (ls_r.mod_cnt != 8'h0)
      ls_nxt.mod_cnt = ls_r.mod_cnt - 8'h1;
    // mode writes touch only the mode store, never the array
    if (cmd_mrs)
    begin
      ls_nxt.mod_cnt = TMOD_CK;
      if (i_ba == `MR0_SEL)
      begin
        ls_nxt.mr0     = i_addr;
        ls_nxt.loaded  = 1'b1;
        ls_nxt.mr0_tog = ~ls_r.mr0_tog;
        ls_nxt.dll_bit = i_addr[`MR0_DLL];
      end
    end
    case (ls_r.st)
      LK_IDLE:
      begin
        // nothing is sequenced before the register holds a real setting
        if ((cmd_rd | cmd_wr) & ls_r.loaded)
        begin
          ls_nxt.st    = LK_LAT;
          ls_nxt.start = i_addr[2:0];
          ls_nxt.wr    = cmd_wr;
          ls_nxt.ord   = ls_r.mr0[`MR0_ORDER];
          ls_nxt.lat   = cmd_wr ? WRITE_LAT : link_cl;
          ls_nxt.beat  = 3'h0;
          case (lmode)
            BL_FIXED4: ls_nxt.chop = 1'b1;
            BL_OTF:    ls_nxt.chop = ~i_addr[`BC_BIT];
            default:   ls_nxt.chop = 1'b0;
          endcase
        end
      end
      LK_LAT:
      begin
        if (ls_r.lat <= 4'h1)
          ls_nxt.st = LK_BEAT;
        else
          ls_nxt.lat = ls_r.lat - 4'h1;
      end
      LK_BEAT:
      begin
        ls_nxt.vld  = 1'b1;
        ls_nxt.col  = seq_col;
        ls_nxt.oe   = ~ls_r.wr & (~ls_r.chop | ~ls_r.beat[2]);
        ls_nxt.wen  = ls_r.wr & (~ls_r.chop | ~ls_r.beat[2]);
        ls_nxt.beat = ls_r.beat + 3'h1;
        if (ls_r.beat == `BURST_LAST)
          ls_nxt.st = LK_IDLE;
      end
      default: ls_nxt.st = LK_IDLE;
    endcase
  end

  always_ff @(posedge i_ck or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      ls_r     <= '0;
      ls_r.mr0 <= `MR0_RESET_VAL;
      ls_r.st  <= LK_IDLE;
    end
    else
      ls_r <= ls_nxt;
  end

  assign o_beat_valid      = ls_r.vld;
  assign o_beat_col        = ls_r.col;
  assign o_dq_oe           = ls_r.oe;
  assign o_wr_beat_en      = ls_r.wen;
  assign o_mrs_settling    = (ls_r.mod_cnt != 8'h0);
  assign o_dll_reset_start = ls_r.dll_bit;

  //////////////////////////////////////////////////////////////////////////////
  // core side: mirror of the register word and decoded settings

  core_st_t cs_r;
  core_st_t cs_nxt;
  logic     tog_edge;

  // word is stable long after the toggle: next mode write is tMRD away
  assign tog_edge = cs_r.tog_s[2] ^ cs_r.tog_s[1];

  always_comb
  begin
    cs_nxt = cs_r;
    if (i_ce)
    begin
      cs_nxt.tog_s   = {cs_r.tog_s[1:0], ls_r.mr0_tog};
      cs_nxt.dll_s   = {cs_r.dll_s[1:0], ls_r.dll_bit};
      cs_nxt.rpin_s  = {cs_r.rpin_s[0], i_dram_reset_n};
      cs_nxt.dll_evt = cs_r.dll_s[1] & ~cs_r.dll_s[2];
      if (tog_edge)
      begin
        cs_nxt.mr0    = ls_r.mr0;
        cs_nxt.loaded = 1'b1;
      end
      // memory reset leaves the register undefined until rewritten
      if (!cs_r.rpin_s[1])
        cs_nxt.loaded = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge crst_n)
  begin
    if (!crst_n)
    begin
      cs_r     <= '0;
      cs_r.mr0 <= `MR0_RESET_VAL;
    end
    else
      cs_r <= cs_nxt;
  end

  // dll reset is a request, so a slow dll-stretch shows only as an event
  assign o_mr0_loaded        = cs_r.loaded;
  assign o_burst_mode        = burst_mode_t'(cs_r.mr0[`MR0_BL_LSB +: 2]);
  assign o_burst_interleaved = cs_r.mr0[`MR0_ORDER];
  assign o_cas_latency       = cl_decode(cs_r.mr0[`MR0_CL_LSB +: 3], cs_r.mr0[`MR0_CL_LOW]);
  assign o_write_recovery    = wr_decode(cs_r.mr0[`MR0_WR_LSB +: 3]);
  assign o_tdal_cycles       = {1'b0, o_write_recovery} + {1'b0, TRP_CK};
  assign o_factory_test      = cs_r.mr0[`MR0_TEST];
  assign o_pd_fast_exit      = cs_r.mr0[`MR0_PD];
  assign o_pd_exit_cycles    = cs_r.mr0[`MR0_PD] ? TXP_CK : TXPDLL_CK;
  assign o_dll_reset_seen    = cs_r.dll_evt;
  assign o_mr0_reserved      = (o_burst_mode == BL_RSVD) | (o_cas_latency == 4'h0)
                               | (o_write_recovery == 4'h0);

  //////////////////////////////////////////////////////////////////////////////
  // checks

  AST_MR0_CAPTURE: assert property (@(posedge i_ck) disable iff (!lrst_n)
    (cmd_mrs && i_ba == `MR0_SEL) |=> (ls_r.mr0 == $past(i_addr) && ls_r.loaded))
    else $error("mode register zero not captured");

  AST_OTHER_MR_KEEP: assert property (@(posedge i_ck) disable iff (!lrst_n)
    (cmd_mrs && i_ba != `MR0_SEL) |=> $stable(ls_r.mr0))
    else $error("mode register zero changed by other bank code");

  AST_DLL_SELF_CLEAR: assert property (@(posedge i_ck) disable iff (!lrst_n)
    ls_r.dll_bit |=> !ls_r.dll_bit)
    else $error("dll reset bit did not clear");

  AST_SETTLE_WINDOW: assert property (@(posedge i_ck) disable iff (!lrst_n)
    cmd_mrs |=> (ls_r.mod_cnt == TMOD_CK))
    else $error("settling window not started");

  AST_CHOP_READ_HIZ: assert property (@(posedge i_ck) disable iff (!lrst_n)
    (ls_r.st == LK_BEAT && !ls_r.wr && ls_r.chop && ls_r.beat[2]) |=> (ls_r.vld && !ls_r.oe))
    else $error("drivers active in chopped tail");

  AST_WRITE_NIBBLE: assert property (@(posedge i_ck) disable iff (!lrst_n)
    (ls_r.st == LK_BEAT && ls_r.wr) |=> (ls_r.col[1:0] == $past(ls_r.beat[1:0])))
    else $error("write beat order wrong");

  AST_INTERLEAVE: assert property (@(posedge i_ck) disable iff (!lrst_n)
    (ls_r.st == LK_BEAT && !ls_r.wr && ls_r.ord)
    |=> (ls_r.col == ($past(ls_r.start) ^ $past(ls_r.beat))))
    else $error("interleaved read order wrong");

  AST_OTF_CHOP: assert property (@(posedge i_ck) disable iff (!lrst_n)
    (ls_r.st == LK_IDLE && ls_r.loaded && lmode == BL_OTF && (cmd_rd || cmd_wr))
    |=> (ls_r.chop == !$past(i_addr[`BC_BIT])))
    else $error("chop not taken from bc pin");

  AST_FIXED8: assert property (@(posedge i_ck) disable iff (!lrst_n)
    (ls_r.st == LK_IDLE && ls_r.loaded && lmode == BL_FIXED8 && cmd_rd) |=> !ls_r.chop)
    else $error("fixed eight burst chopped");

  AST_LAT_COUNT: assert property (@(posedge i_ck) disable iff (!lrst_n)
    (ls_r.st == LK_LAT && ls_r.lat > 4'h1) |=> (ls_r.lat == $past(ls_r.lat) - 4'h1))
    else $error("latency count skipped");

  AST_EIGHT_BEATS: assert property (@(posedge i_ck) disable iff (!lrst_n)
    $rose(ls_r.vld) |-> ls_r.vld [*8] ##1 !ls_r.vld)
    else $error("burst not eight beats");

  AST_PD_EXIT: assert property (@(posedge i_clk) disable iff (!crst_n)
    (tog_edge && i_ce && cs_r.rpin_s[1])
    |=> (o_pd_exit_cycles == ($past(ls_r.mr0[`MR0_PD]) ? TXP_CK : TXPDLL_CK)))
    else $error("powerdown exit time mismatch");

  AST_MIRROR: assert property (@(posedge i_clk) disable iff (!crst_n)
    (tog_edge && i_ce && cs_r.rpin_s[1]) |=> (o_mr0_loaded && cs_r.mr0 == $past(ls_r.mr0)))
    else $error("core copy of register not updated");

  CV_READ_BL8:  cover property (@(posedge i_ck) disable iff (!lrst_n)
    ls_r.vld && ls_r.oe && !ls_r.chop && ls_r.col[2] != ls_r.start[2]);
  CV_READ_BC4:  cover property (@(posedge i_ck) disable iff (!lrst_n)
    ls_r.vld && !ls_r.oe && !ls_r.wr);
  CV_WRITE_BC4: cover property (@(posedge i_ck) disable iff (!lrst_n)
    ls_r.vld && ls_r.wr && ls_r.chop && ls_r.start[2]);
  CV_DLL_RESET: cover property (@(posedge i_clk) disable iff (!crst_n) o_dll_reset_seen);

endmodule // dram_mr0_top

// ==== dram_reset_and_mode_register_zero_tb.sv ====
// self-checking bench for mode register zero, burst order and reset handling
`timescale 1ns/1ps
module dram_reset_and_mode_register_zero_tb;
  import dram_mr0_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_ck = 1'b0;
  logic        i_resetn;
  logic        i_ce;
  logic        rst_n, odt, cke, cs_n, ras_n, cas_n, we_n;
  logic [2:0]  ba, col;
  logic [14:0] addr;
  logic        bv, oe, wen, sett, dlls, ld, ilv, ft, pdf, dseen, rsv;
  logic [3:0]  cas, wrec, pdc;
  logic [4:0]  tdal;
  burst_mode_t bm;
  int          errors = 0;
  int          n_tests = 0;
  int          vcnt = 0;
  int          dll_n = 0;
  int          seen_n = 0;
  int          wrt[8] = '{0, 5, 6, 7, 8, 10, 12, 14};
  // {write, chop, interleave, length code}
  logic [4:0]  mt[7] = '{5'h00, 5'h04, 5'h0a, 5'h0d, 5'h01, 5'h10, 5'h1d};

  always #5 i_clk = ~i_clk;
  initial
  begin
    #7;
    forever #32 i_ck = ~i_ck;
  end

  dram_mr0_top dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_ck(i_ck), .i_dram_reset_n(rst_n),
    .i_cke(cke), .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n),
    .i_ba(ba), .i_addr(addr), .o_beat_valid(bv), .o_beat_col(col), .o_dq_oe(oe),
    .o_wr_beat_en(wen), .o_mrs_settling(sett), .o_dll_reset_start(dlls), .o_mr0_loaded(ld),
    .o_burst_mode(bm), .o_burst_interleaved(ilv), .o_cas_latency(cas),
    .o_write_recovery(wrec), .o_tdal_cycles(tdal), .o_factory_test(ft),
    .o_pd_fast_exit(pdf), .o_pd_exit_cycles(pdc), .o_dll_reset_seen(dseen),
    .o_mr0_reserved(rsv)
  );

  dram_ctrl_model m (
    .i_ck(i_ck), .o_reset_n(rst_n), .o_odt(odt), .o_cke(cke), .o_cs_n(cs_n),
    .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba), .o_addr(addr)
  );

  always @(posedge i_ck)
  begin
    if (bv === 1'b1) vcnt <= vcnt + 1;
    if (dlls === 1'b1) dll_n <= dll_n + 1;
  end
  always @(posedge i_clk)
    if (dseen === 1'b1) seen_n <= seen_n + 1;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one burst; tail beats of a chop are not compared for column
  task automatic burst(input logic [4:0] md, input logic [2:0] s, output int lat);
    logic [2:0] e;
    logic       tail;
    lat = 0;
    m.rw(md[4], {2'b00, ~md[3], 9'h000, s});
    #1;
    while (bv !== 1'b1 && lat < 40)
    begin
      @(posedge i_ck);
      #1;
      lat++;
    end
    for (int b = 0; b < 8; b++)
    begin
      tail = md[3] && b > 3;
      if (md[4])
        e = md[3] ? {s[2], b[1:0]} : b[2:0];
      else
        e = md[2] ? s ^ b[2:0] : {s[2] ^ b[2], s[1:0] + b[1:0]};
      chk("beat_valid", bv, 1'b1);
      if (!tail)
        chk("beat_col", col, e);
      chk("dq_oe", oe, !md[4] && !tail);
      chk("wr_beat_en", wen, md[4] && !tail);
      @(posedge i_ck);
      #1;
    end
    chk("burst_end", bv, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #400000;
    errors++;
    close_out();
  end

  initial
  begin
    logic [14:0] a;
    int          cl, l5, l8, lw, d0, s0;
    i_resetn = 1'b0;
    i_ce = 1'b1;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    m.mem_reset();
    #1;
    chk("loaded", ld, 1'b0);
    d0 = vcnt;
    m.rw(1'b0, 15'h0000);
    repeat (20) @(posedge i_ck);
    chk("early_read", vcnt, d0);
    for (int i = 0; i < 16; i++)
    begin
      a = {2'b00, i[1], i[2:0], 2'b00, i[2:0], i[0], i[3], i[1:0]};
      m.mrs(3'h0, a);
      cl = i[3] ? ((i[2:0] < 3) ? 12 + i[2:0] : 0) : ((i[2:0] != 0) ? i[2:0] + 4 : 0);
      chk("cas_latency", cas, cl);
      chk("write_recovery", wrec, wrt[i[2:0]]);
      chk("tdal", tdal, wrt[i[2:0]] + 9);
      chk("interleaved", ilv, i[0]);
      chk("pd_fast_exit", pdf, i[1]);
      chk("pd_exit_cycles", pdc, i[1] ? 3 : 10);
      chk("loaded", ld, 1'b1);
      chk("factory_test", ft, 1'b0);
      if (i[1:0] != 3)
      begin
        chk("burst_mode", bm, i[1:0]);
        chk("reserved", rsv, cl == 0 || wrt[i[2:0]] == 0);
      end
    end
    m.issue(3'b000, 3'h1, 15'h0010);
    #1;
    d0 = 0;
    while (sett === 1'b1 && d0 < 40)
    begin
      @(posedge i_ck);
      #1;
      d0++;
    end
    chk("settling_cycles", d0, 12);
    m.mrs(3'h4, 15'h0010);
    chk("other_register", cas, 4'h0);
    d0 = dll_n;
    s0 = seen_n;
    m.mrs(3'h0, 15'h0310);
    m.mrs(3'h1, 15'h0000);
    chk("dll_start_pulses", dll_n, d0 + 1);
    chk("dll_seen_pulses", seen_n, s0 + 1);
    // bursts after the dll reset: array behaviour unaffected
    for (int k = 0; k < 7; k++)
    begin
      m.mrs(3'h0, {6'h01, 2'b00, 3'h1, mt[k][2], 1'b0, mt[k][1:0]});
      for (int s = 0; s < 8; s++)
        burst(mt[k], s[2:0], lw);
      if (k == 0)
        l5 = lw;
    end
    m.mrs(3'h0, 15'h0240);
    burst(5'h00, 3'h0, l8);
    chk("latency_step", l8 - l5, 3);
    chk("write_latency", lw, l5);
    // core copy must hold still while the enable is low, then catch up
    @(posedge i_clk);
    i_ce <= 1'b0;
    m.mrs(3'h0, 15'h0248);
    chk("frozen_order", ilv, 1'b0);
    @(posedge i_clk);
    i_ce <= 1'b1;
    repeat (6) @(posedge i_clk);
    chk("thawed_order", ilv, 1'b1);
    m.mem_reset();
    repeat (10) @(posedge i_clk);
    chk("loaded_after_reset", ld, 1'b0);
    close_out();
  end
endmodule // dram_reset_and_mode_register_zero_tb
